// >>> tap_consts.svh
// constants for the boundary-scan shift path
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH
`define IR_W       8
`define IR_CAPTURE 8'h81
`define IR_RESET   8'h7F
`define BND_W      18
`define DIR_BIT    17
`define OEN_BIT    16
`define IN_HI      15
`define IN_LO      8
`define OUT_HI     7
`define OUT_LO     0
`define OP_BND_A   7'h00
`define OP_SAMPLE  7'h02
`define OP_BND_B   7'h03
`define OP_HIGHZ   7'h06
`define OP_RDBN    7'h0A
`define OP_RDBT    7'h0B
`define OP_CELLT   7'h0C
`define BUF_FULL   2'h2
`define BUF_EMPTY  2'h0
`define BUF_ONE    2'h1
`define TLR_TMS_N  3'h5
`endif

// >>> tap_pkg.sv
// types shared by the scan path and its buffer
package tap_pkg;
   typedef enum logic [15:0] {
      TLR    = 16'h0001, RTI    = 16'h0002, SEL_DR = 16'h0004, CAP_DR = 16'h0008,
      SH_DR  = 16'h0010, EX1_DR = 16'h0020, PA_DR  = 16'h0040, EX2_DR = 16'h0080,
      UPD_DR = 16'h0100, SEL_IR = 16'h0200, CAP_IR = 16'h0400, SH_IR  = 16'h0800,
      EX1_IR = 16'h1000, PA_IR  = 16'h2000, EX2_IR = 16'h4000, UPD_IR = 16'h8000
   } tap_state_e;
   typedef logic [17:0] bnd_word_t;
endpackage : tap_pkg

// >>> tap_buf_if.sv
// valid/ready carrier for boundary update words
`timescale 1ns/1ps
`include "tap_consts.svh"
interface tap_buf_if;
   logic              valid;
   logic              ready;
   logic [`BND_W-1:0] data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface : tap_buf_if

// >>> tap_buf.sv
// two-entry buffer for boundary update words
`timescale 1ns/1ps
`include "tap_consts.svh"
module tap_buf
   import tap_pkg::*;
(
   input  wire logic  clk_sys,
   input  wire logic  nrst,
   tap_buf_if.dst     fill,
   tap_buf_if.src     drain
);
   typedef struct packed {
      logic [1:0][`BND_W-1:0] mem;
      logic                   wp;
      logic                   rp;
      logic [1:0]             cnt;
   } buf_s;

   buf_s st;
   buf_s next_st;
   logic push;
   logic pop;

   // ======================================================
   // handshakes
   assign fill.ready  = (st.cnt != `BUF_FULL);
   assign drain.valid = (st.cnt != `BUF_EMPTY);
   assign drain.data  = st.mem[st.rp];
   assign push        = fill.valid & fill.ready;
   assign pop         = drain.valid & drain.ready;

   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wp] = fill.data;
         next_st.wp         = ~st.wp;
      end
      if (pop) begin
         next_st.rp = ~st.rp;
      end
      if (push & ~pop) begin
         next_st.cnt = st.cnt + `BUF_ONE;
      end else if (pop & ~push) begin
         next_st.cnt = st.cnt - `BUF_ONE;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   a_buf_no_over : assert property (@(posedge clk_sys) disable iff (!nrst)
      st.cnt != 2'h3) else $error("buffer count out of range");
endmodule : tap_buf

// >>> tap_scan.sv
// boundary-scan test port shift path for an octal transceiver
//
// How it works
// - entering data shift, first falling edge drives serial out from register lsb.
// - data shift moves one bit per rising edge, including the exiting edge.
// - first falling edge in first data exit turns serial out off.
// - data exits may return to shift; data pause holds contents.
// - boundary latches update on the falling edge in data update.
// - instruction capture loads 10000001 into the instruction shift stage.
// - instruction shift drives lsb from first falling edge, shifts each rising edge.
// - first falling edge in first instruction exit turns serial out off.
// - instruction exits may return to shift; instruction pause holds contents.
// - instruction latches load on the falling edge in instruction update.
// - registers have shift stage plus latch; bypass has only a shift stage.
// - top instruction bit ignored in decode; no parity check.
// - unsupported opcodes act as bypass.
// - power-up and controller reset set the instruction to 01111111.
// - boundary chain is 18 bits, serial in to bit 17 down to 0.
// - boundary chain untouched in reset state; idle changes only per instruction.
// - bit 17 direction, 16 output enable, 15..8 inputs, 7..0 outputs.
// - direction 0 ties inputs to port b, outputs to port a; 1 swaps.
// - in normal mode the direction cell follows the direction pin.
// - sample on rising test clock edges, change outputs on falling edges.
// - controller reaches reset within five edges with mode select high.
// - bypass bit captures zero in data capture.
`timescale 1ns/1ps
`include "tap_consts.svh"
module tap_scan
   import tap_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              nrst,
   input  wire logic              tck,
   input  wire logic              tms,
   input  wire logic              tdi,
   output logic                   tdo,
   output logic                   tdo_oe,
   input  wire logic              dir,
   input  wire logic              oe_n,
   input  wire logic [7:0]        port_a_pins_in,
   output logic      [7:0]        port_a_pins_out,
   output logic      [7:0]        port_a_pins_oe,
   input  wire logic [7:0]        port_b_pins_in,
   output logic      [7:0]        port_b_pins_out,
   output logic      [7:0]        port_b_pins_oe,
   output logic [`BND_W-1:0]      upd_data,
   output logic                   upd_valid,
   input  wire logic              upd_ready,
   output logic [`IR_W-1:0]       test_opcode_register
);
   typedef struct packed {
      logic              tck_s1, tck_s2, tck_d;
      logic              tms_s1, tms_s2, tdi_s1, tdi_s2;
      logic              dir_s1, dir_s2, oen_s1, oen_s2;
      logic [7:0]        a_s1, a_s2, b_s1, b_s2;
      tap_state_e        tap;
      logic [`IR_W-1:0]  ir_sh, ir;
      logic [`BND_W-1:0] bnd_sh, bnd;
      logic              byp;
      logic              tdo, tdo_oe, fall_wait;
      logic [7:0]        a_out, a_oe, b_out, b_oe;
   } scan_s;

   scan_s       st;
   scan_s       next_st;
   tap_buf_if   fill_if ();
   tap_buf_if   drain_if ();
   logic        rise;
   logic        fall;
   logic        fall_go;
   logic        bsel;
   logic        tmode;
   logic        dir_eff;
   logic        oen_eff;
   logic        need_push;

   // ======================================================
   // decode helpers
   // sixteen-state controller
   function automatic tap_state_e tap_next(input tap_state_e s, input logic m);
      unique case (s)
         TLR:    tap_next = m ? TLR    : RTI;
         RTI:    tap_next = m ? SEL_DR : RTI;
         SEL_DR: tap_next = m ? SEL_IR : CAP_DR;
         CAP_DR: tap_next = m ? EX1_DR : SH_DR;
         SH_DR:  tap_next = m ? EX1_DR : SH_DR;
         EX1_DR: tap_next = m ? UPD_DR : PA_DR;
         PA_DR:  tap_next = m ? EX2_DR : PA_DR;
         EX2_DR: tap_next = m ? UPD_DR : SH_DR;
         UPD_DR: tap_next = m ? SEL_DR : RTI;
         SEL_IR: tap_next = m ? TLR    : CAP_IR;
         CAP_IR: tap_next = m ? EX1_IR : SH_IR;
         SH_IR:  tap_next = m ? EX1_IR : SH_IR;
         EX1_IR: tap_next = m ? UPD_IR : PA_IR;
         PA_IR:  tap_next = m ? EX2_IR : PA_IR;
         EX2_IR: tap_next = m ? UPD_IR : SH_IR;
         UPD_IR: tap_next = m ? SEL_DR : RTI;
         default: tap_next = TLR;
      endcase
   endfunction : tap_next

   // anything not listed falls to bypass
   function automatic logic bnd_selected(input logic [`IR_W-1:0] op);
      unique case (op[6:0])
         `OP_BND_A, `OP_SAMPLE, `OP_BND_B, `OP_RDBN, `OP_RDBT, `OP_CELLT:
            bnd_selected = 1'b1;
         default: bnd_selected = 1'b0;
      endcase
   endfunction : bnd_selected

   function automatic logic test_mode(input logic [`IR_W-1:0] op);
      test_mode = (op[6:0] == `OP_BND_A) | (op[6:0] == `OP_BND_B) | (op[6:0] == `OP_RDBT);
   endfunction : test_mode

   // pin 1 sits at the high end of each cell group
   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) begin
         rev8[7 - i] = v[i];
      end
   endfunction : rev8

   // ======================================================
   // edges of the sampled test clock
   assign rise      = st.tck_s2 & ~st.tck_d;
   assign fall      = ~st.tck_s2 & st.tck_d;
   assign bsel      = bnd_selected(st.ir);
   assign tmode     = test_mode(st.ir);
   assign dir_eff   = tmode ? st.bnd[`DIR_BIT] : st.dir_s2;
   assign oen_eff   = tmode ? st.bnd[`OEN_BIT] : st.oen_s2;
   assign need_push = (st.tap == UPD_DR) & bsel;
   // a stalled reader delays the latch update; a stall past the next rising edge drops it
   assign fall_go   = (fall | st.fall_wait) & ~(need_push & ~fill_if.ready);

   // ======================================================
   // next state
   always_comb begin
      next_st        = st;
      next_st.tck_s1 = tck;
      next_st.tck_s2 = st.tck_s1;
      next_st.tck_d  = st.tck_s2;
      next_st.tms_s1 = tms;
      next_st.tms_s2 = st.tms_s1;
      next_st.tdi_s1 = tdi;
      next_st.tdi_s2 = st.tdi_s1;
      next_st.dir_s1 = dir;
      next_st.dir_s2 = st.dir_s1;
      next_st.oen_s1 = oe_n;
      next_st.oen_s2 = st.oen_s1;
      next_st.a_s1   = port_a_pins_in;
      next_st.a_s2   = st.a_s1;
      next_st.b_s1   = port_b_pins_in;
      next_st.b_s2   = st.b_s1;

      if (rise) begin
         unique case (st.tap)
            CAP_DR: begin
               if (bsel) begin
                  next_st.bnd_sh = {st.dir_s2, st.oen_s2,
                                    rev8(dir_eff ? st.a_s2 : st.b_s2),
                                    rev8(dir_eff ? st.b_out : st.a_out)};
               end else begin
                  next_st.byp = 1'b0;
               end
            end
            // serial in enters at bit 17
            SH_DR: begin
               if (bsel) begin
                  next_st.bnd_sh = {st.tdi_s2, st.bnd_sh[`BND_W-1:1]};
               end else begin
                  next_st.byp = st.tdi_s2;
               end
            end
            CAP_IR: next_st.ir_sh = `IR_CAPTURE;
            SH_IR: next_st.ir_sh = {st.tdi_s2, st.ir_sh[`IR_W-1:1]};
            // pause and exits leave the stages alone
            // reset and idle never touch the chain
            default: ;
         endcase
         // mode select high walks to reset
         next_st.tap = tap_next(st.tap, st.tms_s2);
      end

      next_st.fall_wait = (fall | st.fall_wait) & ~fall_go;
      if (fall_go) begin
         next_st.tdo_oe = (st.tap == SH_DR) | (st.tap == SH_IR);
         next_st.tdo    = (st.tap == SH_IR) ? st.ir_sh[0] :
                          (bsel ? st.bnd_sh[0] : st.byp);
         if (st.tap == UPD_IR) begin
            next_st.ir = st.ir_sh;
         end
         // latches kept apart from shift stages
         if (need_push) begin
            next_st.bnd = st.bnd_sh;
         end
         if (st.tap == TLR) begin
            next_st.ir = `IR_RESET;
         end
      end

      next_st.a_oe  = (~oen_eff & ~dir_eff & (st.ir[6:0] != `OP_HIGHZ)) ? 8'hFF : 8'h00;
      next_st.b_oe  = (~oen_eff &  dir_eff & (st.ir[6:0] != `OP_HIGHZ)) ? 8'hFF : 8'h00;
      next_st.a_out = tmode ? rev8(st.bnd[`OUT_HI:`OUT_LO]) : st.b_s2;
      next_st.b_out = tmode ? rev8(st.bnd[`OUT_HI:`OUT_LO]) : st.a_s2;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st        <= '0;
         st.tap    <= TLR;
         st.ir     <= `IR_RESET;
         st.ir_sh  <= `IR_RESET;
         st.tck_s1 <= 1'b1;
         st.tck_s2 <= 1'b1;
         st.tck_d  <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ======================================================
   // update word buffer
   assign fill_if.valid  = (fall | st.fall_wait) & need_push;
   assign fill_if.data   = st.bnd_sh;
   assign upd_data       = drain_if.data;
   assign upd_valid      = drain_if.valid;
   assign drain_if.ready = upd_ready;

   tap_buf u_buf (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .fill    (fill_if.dst),
      .drain   (drain_if.src)
   );

   assign tdo                  = st.tdo;
   assign tdo_oe               = st.tdo_oe;
   assign port_a_pins_out      = st.a_out;
   assign port_a_pins_oe       = st.a_oe;
   assign port_b_pins_out      = st.b_out;
   assign port_b_pins_oe       = st.b_oe;
   assign test_opcode_register = st.ir;

   // ======================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   logic [2:0] tms_run;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         tms_run <= 3'h0;
      end else if (rise) begin
         tms_run <= !st.tms_s2 ? 3'h0 : (tms_run == `TLR_TMS_N) ? tms_run : tms_run + 3'h1;
      end
   end

   sequence s_pause_dr;
      st.tap == PA_DR ##1 st.tap == PA_DR;
   endsequence
   sequence s_pause_ir;
      st.tap == PA_IR ##1 st.tap == PA_IR;
   endsequence

   a_tdo_on_dr    : assert property (fall_go && st.tap == SH_DR |=> st.tdo_oe)
      else $error("serial out not driven in data shift");
   a_dr_shift     : assert property (rise && st.tap == SH_DR && bsel
      |=> st.bnd_sh == {$past(st.tdi_s2), $past(st.bnd_sh[`BND_W-1:1])})
      else $error("boundary shift wrong");
   a_tdo_off_dr   : assert property (fall_go && st.tap == EX1_DR |=> !st.tdo_oe)
      else $error("serial out still on in data exit");
   a_pause_hold   : assert property (s_pause_dr |-> $stable(st.bnd_sh) && $stable(st.byp))
      else $error("data pause lost contents");
   a_ir_capture   : assert property (rise && st.tap == CAP_IR |=> st.ir_sh == `IR_CAPTURE)
      else $error("instruction capture pattern wrong");
   a_ir_shift     : assert property (rise && st.tap == SH_IR
      |=> st.ir_sh == {$past(st.tdi_s2), $past(st.ir_sh[`IR_W-1:1])})
      else $error("instruction shift wrong");
   a_tdo_off_ir   : assert property (fall_go && st.tap == EX1_IR |=> !st.tdo_oe)
      else $error("serial out still on in instruction exit");
   a_ir_pause     : assert property (s_pause_ir |-> $stable(st.ir_sh))
      else $error("instruction pause lost contents");
   a_ir_update    : assert property (fall_go && st.tap == UPD_IR |=> st.ir == $past(st.ir_sh))
      else $error("instruction latch not updated");
   a_ir_reset     : assert property (fall_go && st.tap == TLR |=> st.ir == `IR_RESET)
      else $error("reset state did not force bypass");
   a_tlr_reach    : assert property (tms_run == `TLR_TMS_N |-> st.tap == TLR)
      else $error("controller not in reset after five high edges");
   a_byp_zero     : assert property (rise && st.tap == CAP_DR && !bsel |=> !st.byp)
      else $error("bypass did not capture zero");
endmodule : tap_scan

// >>> tap_master.sv
// test bus controller model driving the scan port
`timescale 1ns/1ps
module tap_master (
   input  wire logic clk_sys,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo_pin,
   input  wire logic tdo_oe
);
   logic last_tdo;
   logic last_oe;

   // test clock stands still high between frames
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // ==========================================================
   // one test clock cycle, 4 system clocks per half
   // change after fall, hold across rise
   task automatic step(input logic m, input logic d);
      tck = 1'b0;
      tms = m;
      tdi = d;
      repeat (4) begin @(posedge clk_sys); #1; end
      tck = 1'b1;
      repeat (3) begin @(posedge clk_sys); #1; end
      // sampled late in the high phase, where the value has settled
      last_tdo = tdo_pin;
      last_oe  = tdo_oe;
      // hold time over: line no longer shows the last bit
      tdi      = ~d;
      @(posedge clk_sys);
      #1;
   endtask : step

   // ==========================================================
   // mode select sequence, first bit first
   task automatic go(input int n, input logic [7:0] seq);
      for (int i = 0; i < n; i++) step(seq[i], 1'b0);
   endtask : go

   // n bits lsb first, last one leaves shift
   task automatic shift(input int n, input logic [17:0] din, output logic [17:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i]);
         dout[i] = last_tdo;
      end
   endtask : shift
endmodule : tap_master

// >>> boundary_scan_tap_shift_path_tb.sv
// self-checking bench for the boundary-scan shift path
`timescale 1ns/1ps
module boundary_scan_tap_shift_path_tb;
   logic        clk_sys = 1'b0;
   logic        nrst, tck, tms, tdi, tdo, tdo_oe, tdo_pin, dir, oe_n;
   logic [7:0]  pa_in, pb_in, pa_out, pa_oe, pb_out, pb_oe, op;
   logic [17:0] upd_data, w1, w2, d;
   logic        upd_valid, upd_ready;
   logic [17:0] exp_q[$];
   logic [31:0] seed  = 32'd39181;
   logic [31:0] rseed = 32'd39181 ^ 32'h5A5A;
   int          fail_count = 0;
   int          checked    = 0;

   always #5 clk_sys = ~clk_sys;
   // pull-up on the serial output pin
   assign tdo_pin = tdo_oe ? tdo : 1'b1;

   tap_scan u_tap_scan (.clk_sys(clk_sys), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .dir(dir), .oe_n(oe_n), .port_a_pins_in(pa_in),
      .port_a_pins_out(pa_out), .port_a_pins_oe(pa_oe), .port_b_pins_in(pb_in),
      .port_b_pins_out(pb_out), .port_b_pins_oe(pb_oe), .upd_data(upd_data),
      .upd_valid(upd_valid), .upd_ready(upd_ready), .test_opcode_register(op));
   tap_master u_tap_master (.clk_sys(clk_sys), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo_pin(tdo_pin), .tdo_oe(tdo_oe));

   // ==========================================================
   // helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   // pin 1 of a group sits at the high cell of that group
   function automatic logic [7:0] flip8(input logic [7:0] v);
      for (int i = 0; i < 8; i++) flip8[i] = v[7 - i];
   endfunction : flip8

   task automatic check(input logic [17:0] got, input logic [17:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   task automatic wclk(input int n);
      repeat (n) begin @(posedge clk_sys); #1; end
   endtask : wclk

   task automatic load_ir(input logic [7:0] v);
      u_tap_master.go(4, 8'h03);
      u_tap_master.shift(8, {10'h000, v}, d);
      check(d[7:0], 8'h81, "capture pattern");
      // exit1 falls here, then pause, exit2, update, idle
      u_tap_master.step(1'b0, 1'b0);
      check(u_tap_master.last_oe, 1'b0, "oe after exit");
      u_tap_master.go(4, 8'h06);
      wclk(6);
      check(op, v, "instruction latch");
   endtask : load_ir

   task automatic final_report;
      $display("comparisons %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : final_report

   // ==========================================================
   // random stalls on the update side
   always @(posedge clk_sys) begin
      rseed <= xs(rseed);
      upd_ready <= #1 rseed[3];
   end

   // watcher: each accepted word against the oldest note
   always @(posedge clk_sys) begin
      if (nrst === 1'b1 && upd_valid === 1'b1 && upd_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            fail_count++;
            $display("mismatch at %0t: unexpected update word", $time);
         end else begin
            check(upd_data, exp_q.pop_front(), "update word");
         end
      end
   end

   initial begin
      #400000;
      fail_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      final_report();
   end

   // ==========================================================
   // main sequence
   initial begin
      nrst = 1'b0;
      dir = 1'b0;
      oe_n = 1'b0;
      pa_in = 8'h00;
      pb_in = 8'h00;
      repeat (6) @(posedge clk_sys);
      #1 nrst = 1'b1;
      wclk(4);
      check(op, 8'h7F, "reset instruction");
      check(tdo_oe, 1'b0, "idle serial out");
      seed = xs(seed);
      dir = 1'b1;
      pa_in = seed[7:0];
      wclk(8);
      check(pb_out, pa_in, "b from a");
      check(pb_oe, 8'hFF, "b driven");
      check(pa_oe, 8'h00, "a released");
      dir = 1'b0;
      pb_in = seed[15:8];
      wclk(8);
      check(pa_out, pb_in, "a from b");
      check(pa_oe, 8'hFF, "a driven");
      check(pb_oe, 8'h00, "b released");
      oe_n = 1'b1;
      wclk(8);
      check(pa_oe | pb_oe, 8'h00, "disabled");
      oe_n = 1'b0;
      wclk(8);
      u_tap_master.go(1, 8'h00);
      // top bit set: still decodes as sample
      load_ir(8'h82);
      for (int k = 0; k < 3; k++) begin
         seed = xs(seed);
         w1 = seed[17:0];
         seed = xs(seed);
         w2 = seed[17:0];
         u_tap_master.go(3, 8'h01);
         u_tap_master.shift(18, w1, d);
         check(d[17], 1'b0, "direction cell");
         check(d[15:8], flip8(pb_in), "input cells");
         // from exit1: pause twice, exit2, back to shift
         u_tap_master.go(4, 8'h04);
         u_tap_master.shift(18, w2, d);
         check(d, w1, "shifted word kept");
         exp_q.push_back(w2);
         // exit1 to update, then idle
         u_tap_master.go(2, 8'h01);
      end
      // test mode: pins follow the latched chain
      load_ir(8'h00);
      check(pa_out, flip8(w2[7:0]), "a from chain");
      check(pb_out, flip8(w2[7:0]), "b from chain");
      check(pa_oe, {8{~w2[16] & ~w2[17]}}, "a enable from chain");
      check(pb_oe, {8{~w2[16] & w2[17]}}, "b enable from chain");
      load_ir(8'h06);
      check(pa_oe | pb_oe, 8'h00, "high impedance");
      load_ir(8'h85);
      u_tap_master.go(3, 8'h01);
      u_tap_master.shift(4, 18'h0000B, d);
      check(d[3:0], 4'h6, "bypass path");
      u_tap_master.go(3, 8'h03);
      // five high edges reach reset, the sixth gives it a falling edge
      u_tap_master.go(6, 8'h3F);
      wclk(6);
      check(op, 8'h7F, "controller reset");
      wclk(20);
      check(exp_q.size(), 18'h0, "words outstanding");
      final_report();
   end
endmodule : boundary_scan_tap_shift_path_tb
